// File: rtl/rst_seq.sv
// Purpose: Reset-out delay, strap capture, async input sync, timer pulse stretch
// Assumes: ext_rst_n and all strap/async pins are asynchronous to clk
// Notes:   Core clock is a strobe of one clk cycle every ratio cycles
module rst_seq
  import rst_seq_pkg::*;
#(
  parameter int N_LINES   = 4,
  parameter int DELAY_CYC = RST_OUT_DELAY_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // External reset and reset-out
  input  wire logic               ext_rst_n,
  output logic                    rst_out_n,
  // Straps
  input  wire logic [2:0]         core_clock_ratio_strap,
  output logic [2:0]              core_clock_ratio,
  output logic                    timer0_strap,
  // Core clock strobe
  output logic                    core_clock,
  // Asynchronous inputs, active low requests
  input  wire logic [N_LINES-1:0] interrupt_request_lines_n,
  input  wire logic [N_LINES-1:0] dma_request_lines_n,
  input  wire logic [N_LINES-1:0] general_flag_inputs,
  output logic [N_LINES-1:0]      irq_sync_n,
  output logic [N_LINES-1:0]      dmar_sync_n,
  output logic [N_LINES-1:0]      flag_sync,
  // Timer expired
  input  wire logic               timer0_expired_evt,
  input  wire logic               timer0_expired_in,
  output logic                    timer0_expired_out,
  output logic                    timer0_expired_oe
);

  // ****************************************
  // Synchronisers
  // ****************************************
  localparam int W         = 3 * N_LINES + 4 + 1;
  localparam int TMR_POS   = 0;
  localparam int RATIO_LSB = 1;
  localparam int EXT_POS   = 4;
  localparam int FLAG_LSB  = 5;
  localparam int DMA_LSB   = FLAG_LSB + N_LINES;
  localparam int IRQ_LSB   = DMA_LSB + N_LINES;

  // Idle pattern after reset: requests released, external reset still seen low,
  // so no false request or early release follows sys_rst
  localparam logic [W-1:0] SYNC_IDLE = {{(2 * N_LINES){1'b1}}, {N_LINES{1'b0}},
                                        1'b0, RATIO_RESET, TMR_STRAP_RESET};

  logic [W-1:0] pin_w;
  logic [W-1:0] stage_r [SYNC_STAGES];
  logic [W-1:0] sync_r;
  logic         ext_rst_s;
  logic [2:0]   ratio_s;
  logic         tmr_s;

  // Picks one group of lines out of the synchronised word
  function automatic logic [N_LINES-1:0] group_at(input logic [W-1:0] v, input int lsb);
    group_at = v[lsb +: N_LINES];
  endfunction : group_at

  assign pin_w = {interrupt_request_lines_n, dma_request_lines_n, general_flag_inputs,
                  ext_rst_n, core_clock_ratio_strap, timer0_expired_in};

  // Only the last stage is read by logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int s = 0; s < SYNC_STAGES; s++) begin
        stage_r[s] <= SYNC_IDLE;
      end
    end else begin
      stage_r[0] <= pin_w;                             // see [RULE2]
      for (int s = 1; s < SYNC_STAGES; s++) begin
        stage_r[s] <= stage_r[s-1];
      end
    end
  end

  assign sync_r    = stage_r[SYNC_STAGES-1];
  assign ext_rst_s = ~sync_r[EXT_POS];
  assign ratio_s   = sync_r[RATIO_LSB +: 3];
  assign tmr_s     = sync_r[TMR_POS];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_sync_n  <= '1;
      dmar_sync_n <= '1;
      flag_sync   <= '0;
    end else begin
      irq_sync_n  <= group_at(sync_r, IRQ_LSB);        // see [RULE1]
      dmar_sync_n <= group_at(sync_r, DMA_LSB);
      flag_sync   <= group_at(sync_r, FLAG_LSB);
    end
  end

  // ****************************************
  // Reset-out delay
  // ****************************************
  localparam int            CW       = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] DLY_LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] dly_r;
  logic          in_rst_r;
  logic          dly_done;

  // Last counted cycle of the release delay
  assign dly_done = in_rst_r && (dly_r == DLY_LAST);

  // Counter restarts on every sight of external reset
  always_ff @(posedge clk) begin
    if (sys_rst || ext_rst_s) begin
      dly_r <= '0;                                     // see [RULE10]
    end else if (in_rst_r) begin
      dly_r <= dly_r + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || ext_rst_s) begin
      in_rst_r <= 1'b1;
    end else if (dly_done) begin
      in_rst_r <= 1'b0;
    end
  end

  // Reset-out stays low as long as external reset is seen
  always_ff @(posedge clk) begin
    if (sys_rst || ext_rst_s) begin
      rst_out_n <= 1'b0;                               // see [RULE10]
    end else if (dly_done) begin
      rst_out_n <= 1'b1;                               // see [RULE9]
    end
  end

  // ****************************************
  // Strap capture while in reset
  // ****************************************
  // Straps are followed every cycle in reset and frozen at release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_clock_ratio <= RATIO_RESET;
    end else if (in_rst_r) begin
      core_clock_ratio <= ratio_s;                     // see [RULE4]
    end
  end

  // Timer pin reads low here through the pad pull-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer0_strap <= TMR_STRAP_RESET;
    end else if (in_rst_r) begin
      timer0_strap <= tmr_s;                           // see [RULE3]
    end
  end

  // ****************************************
  // Core clock strobe
  // ****************************************
  logic [2:0] div_r;
  logic [2:0] ratio_last;
  logic       div_wrap;

  // Ratio 0 is taken as 1: a strobe every cycle
  assign ratio_last = (core_clock_ratio == 3'h0) ? 3'h0 : core_clock_ratio - 3'h1;
  assign div_wrap   = (div_r >= ratio_last);

  always_ff @(posedge clk) begin
    if (sys_rst || in_rst_r) begin
      div_r <= '0;
    end else if (div_wrap) begin
      div_r <= '0;                                     // see [RULE4]
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // Strobe stays quiet while the core is held in reset
  always_ff @(posedge clk) begin
    if (sys_rst || in_rst_r) begin
      core_clock <= 1'b0;
    end else begin
      core_clock <= div_wrap;                          // see [RULE4]
    end
  end

  // ****************************************
  // Timer expired pulse, active low
  // ****************************************
  logic [2:0] tmr_cnt_r;
  logic       tmr_hold;

  // A new event restarts the count, so the low time only grows
  assign tmr_hold = (tmr_cnt_r != 3'h0);

  always_ff @(posedge clk) begin
    if (sys_rst || in_rst_r) begin
      tmr_cnt_r <= '0;
    end else if (timer0_expired_evt) begin
      tmr_cnt_r <= 3'(TMR_LOW_MIN_CYC - 1);            // see [RULE3]
    end else if (tmr_hold) begin
      tmr_cnt_r <= tmr_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || in_rst_r) begin
      timer0_expired_out <= 1'b1;
    end else if (timer0_expired_evt) begin
      timer0_expired_out <= 1'b0;                      // see [RULE3]
    end else if (!tmr_hold) begin
      timer0_expired_out <= 1'b1;
    end
  end

  // Pin is released in reset so it can serve as a strap
  always_ff @(posedge clk) begin
    if (sys_rst || in_rst_r) begin
      timer0_expired_oe <= 1'b0;                       // see [RULE3]
    end else if (timer0_expired_evt) begin
      timer0_expired_oe <= 1'b1;
    end else if (!tmr_hold) begin
      timer0_expired_oe <= 1'b0;
    end
  end

endmodule : rst_seq

// File: rtl/rst_seq_pkg.sv
// Purpose: Constants for reset sequencing and asynchronous input qualification
// Assumes: System clock at 200 MHz
// Notes:   Times are kept in their printed unit; cycle counts derive from them
// Behaviour
// [RULE1] Every pin except the asynchronous request, flag and timer pins is sampled and driven on system clock edges.
// [RULE2] Interrupt, DMA-request and flag inputs are synchronized inside and must each stay low and high for at least 2 clock periods.
// [RULE3] The timer-expired output is driven low for at least 4 clock periods and is a strap input held low during reset.
// [RULE4] The core clock period is the system clock period divided by the strapped clock ratio; the code makes it ratio times the clk period.
// [RULE5] At power-up external reset stays asserted until 2 ms after supplies, clock and straps are stable.
// [RULE6] Test reset is asserted for at least 100 clock periods during power-up reset before external reset is released.
// [RULE7] A normal reset holds external reset asserted for at least 2 ms.
// [RULE8] Straps are stable at least 1.5 ms before external reset is released.
// [RULE9] Reset-out is released no sooner than 1.5 ms after external reset is deasserted.
// [RULE10] Reset-out follows external reset while it is asserted and the delay counts clock cycles from its release.
package rst_seq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_PS       = 5000;
  localparam int          RST_OUT_DELAY_US    = 1500;
  localparam int          RST_OUT_DELAY_CYC   =
    (RST_OUT_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          ASYNC_MIN_PULSE_CYC = 2;
  localparam int          TMR_LOW_MIN_CYC     = 4;
  localparam int          SYNC_STAGES         = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0]  RATIO_RESET         = 3'h0;
  localparam logic        TMR_STRAP_RESET     = 1'h0;

endpackage : rst_seq_pkg

// File: verif/board_model.sv
// Purpose: board reset source and pin pull. Assumes: clk. Notes: hold shortened
module board_model #(parameter int HOLD = 8, parameter int TRST = 100) (
  // Board side
  input  wire logic       clk, rst_req, timer0_expired_out, timer0_expired_oe,
  input  wire logic [2:0] ratio_sel,
  output logic            ext_rst_n, timer0_expired_in,
  output logic [2:0]      core_clock_ratio_strap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h8;
  logic [6:0] trst_r = 7'h64;
  logic       test_rst_n;
  // Short hold stands in for the long board hold
  always_ff @(posedge clk) cnt_r <= rst_req ? 4'(HOLD) : cnt_r - 4'(cnt_r != 0);
  // Test reset is held TRST cycles and external reset waits for it
  always_ff @(posedge clk) trst_r <= rst_req ? 7'(TRST) : trst_r - 7'(trst_r != 0);
  assign test_rst_n = (trst_r == 7'h0);
  assign ext_rst_n = (cnt_r == 4'h0) && test_rst_n;
  assign core_clock_ratio_strap = ratio_sel;
  assign timer0_expired_in = timer0_expired_oe ? timer0_expired_out : 1'b0;
endmodule : board_model

// File: verif/rst_seq_asserts.sv
// Purpose: port checks. Assumes: one clock. Notes: bound to rst_seq
module rst_seq_asserts #(parameter int DELAY_CYC = 20, parameter int N_LINES = 4) (
  input wire logic               clk, sys_rst, ext_rst_n, rst_out_n, core_clock,
  input wire logic               timer0_expired_evt, timer0_expired_out, timer0_expired_oe,
  input wire logic [N_LINES-1:0] interrupt_request_lines_n, dma_request_lines_n,
  input wire logic [N_LINES-1:0] general_flag_inputs, irq_sync_n, dmar_sync_n, flag_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  int hi_r;
  logic [1:0] up_r;
  always_ff @(posedge clk) hi_r <= (sys_rst || !ext_rst_n) ? 0 : hi_r + 1;
  always_ff @(posedge clk) up_r <= sys_rst ? 2'h0 : up_r + 2'(up_r != 2'h3);
  sequence s_low4; !timer0_expired_out[*4]; endsequence
  property p_hold; !ext_rst_n[*5] |-> !rst_out_n; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_delay; $rose(rst_out_n) |-> hi_r >= DELAY_CYC; endproperty
  a_delay: assert property (p_delay) else $error("early");
  property p_tgo; timer0_expired_evt && rst_out_n |=> !timer0_expired_out && timer0_expired_oe; endproperty
  a_tgo: assert property (p_tgo) else $error("tgo");
  property p_tlen; $fell(timer0_expired_out) |-> s_low4; endproperty
  a_tlen: assert property (p_tlen) else $error("tlen");
  property p_cstop; !$past(rst_out_n) |-> !core_clock; endproperty
  a_cstop: assert property (p_cstop) else $error("cstop");
  property p_sync;
    up_r == 2'h3 |-> {irq_sync_n, dmar_sync_n, flag_sync} ==
      $past({interrupt_request_lines_n, dma_request_lines_n, general_flag_inputs}, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("sync");
endmodule : rst_seq_asserts
bind rst_seq rst_seq_asserts #(.DELAY_CYC(DELAY_CYC), .N_LINES(N_LINES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n), .rst_out_n(rst_out_n),
  .core_clock(core_clock), .timer0_expired_evt(timer0_expired_evt),
  .timer0_expired_out(timer0_expired_out), .timer0_expired_oe(timer0_expired_oe),
  .interrupt_request_lines_n(interrupt_request_lines_n),
  .dma_request_lines_n(dma_request_lines_n), .general_flag_inputs(general_flag_inputs),
  .irq_sync_n(irq_sync_n), .dmar_sync_n(dmar_sync_n), .flag_sync(flag_sync));

// File: verif/rst_seq_tb_top.sv
// Purpose: rst_seq bench. Assumes: 200 MHz. Notes: delay shortened to DLY
module rst_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  logic clk = 0, sys_rst = 1, rst_req = 0, timer0_expired_evt = 0;
  logic ext_rst_n, rst_out_n, core_clock, timer0_strap, timer0_expired_in;
  logic timer0_expired_out, timer0_expired_oe;
  logic [2:0] ratio_sel = 3'h0, core_clock_ratio_strap, core_clock_ratio;
  logic [3:0] interrupt_request_lines_n = 4'hf, dma_request_lines_n = 4'hf;
  logic [3:0] general_flag_inputs = 4'h0, irq_sync_n, dmar_sync_n, flag_sync;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  rst_seq #(.DELAY_CYC(DLY)) DUT (
    .clk(clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n), .rst_out_n(rst_out_n),
    .core_clock_ratio_strap(core_clock_ratio_strap), .core_clock_ratio(core_clock_ratio),
    .timer0_strap(timer0_strap), .core_clock(core_clock),
    .interrupt_request_lines_n(interrupt_request_lines_n),
    .dma_request_lines_n(dma_request_lines_n), .general_flag_inputs(general_flag_inputs),
    .irq_sync_n(irq_sync_n), .dmar_sync_n(dmar_sync_n), .flag_sync(flag_sync),
    .timer0_expired_evt(timer0_expired_evt), .timer0_expired_in(timer0_expired_in),
    .timer0_expired_out(timer0_expired_out), .timer0_expired_oe(timer0_expired_oe));
  board_model u_board (
    .clk(clk), .rst_req(rst_req), .timer0_expired_out(timer0_expired_out),
    .timer0_expired_oe(timer0_expired_oe), .ratio_sel(ratio_sel), .ext_rst_n(ext_rst_n),
    .timer0_expired_in(timer0_expired_in), .core_clock_ratio_strap(core_clock_ratio_strap));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin n_mismatch++; wrap_up(); end
  task automatic tick(int n); repeat (n) @(posedge clk); #1; endtask : tick
  task automatic chk(string s, logic [11:0] e, logic [11:0] g);
    n_compared++;
    if (g !== e) begin n_mismatch++; $display("ERROR %s expected %h seen %h", s, e, g); end
  endtask : chk
  task automatic drv(logic [11:0] v);
    {interrupt_request_lines_n, dma_request_lines_n, general_flag_inputs} = v;
  endtask : drv
  task automatic t_reset(logic [2:0] r);
    int n = 0;
    ratio_sel = r;
    rst_req = 1;
    tick(1);
    rst_req = 0;
    tick(5);
    chk("rst_out_n", 0, rst_out_n);
    while (!ext_rst_n) tick(1);
    while (rst_out_n !== 1'b1 && n < DLY + 9) begin tick(1); n++; end
    chk("delay", 1, n >= DLY && n <= DLY + 4);
    chk("straps", {r, 1'b0}, {core_clock_ratio, timer0_strap});
    n = 0;
    repeat (30) begin tick(1); n += core_clock; end
    chk("core_clock", 30 / (r == 3'h0 ? 1 : r), n);
    $display("reset test done");
  endtask : t_reset
  task automatic t_timer;
    int n = 0;
    timer0_expired_evt = 1;
    tick(1);
    timer0_expired_evt = 0;
    chk("timer_oe", 1, timer0_expired_oe);
    while (timer0_expired_out === 1'b0 && n < 9) begin tick(1); n++; end
    chk("timer_low", 4, n);
    chk("timer_oe_off", 0, timer0_expired_oe);
    chk("pin_idle", 0, timer0_expired_in);
    $display("timer test done");
  endtask : t_timer
  task automatic t_sync;
    drv(12'hed4);
    tick(2);
    drv(12'hff0);
    tick(1);
    chk("sync_low", 12'hed4, {irq_sync_n, dmar_sync_n, flag_sync});
    tick(2);
    chk("sync_high", 12'hff0, {irq_sync_n, dmar_sync_n, flag_sync});
    $display("sync test done");
  endtask : t_sync
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    tick(2);
    sys_rst = 0;
    t_reset(3'h3);
    t_timer();
    t_sync();
    t_reset(3'h0);
    t_reset(3'h5);
    tick(20);
    wrap_up();
  end
endmodule : rst_seq_tb_top
